//--- logic/iebu_consts.svh
// Constants of the upper interrupt enable bank: offsets, masks and reset values.
// Operation
// - A set enable bit passes its source request; a clear bit blocks it.
// - Every implemented enable bit is read/write and clears at power-on reset.
// - Unimplemented bit positions ignore writes and always read back as zero.
// - Word3 bits 3..0 gate unit7 timer, I2C2 master, I2C2 slave, unit6 timer.
// - Word4 bits 14,13,9,8 used; bits 15 and 12..10 are unimplemented.
// - Word4 bits 7,6,3,2,1,0 used; bits 5..4 are unimplemented.
// - Word5 bits 15..8 gate compare, SPI and UART4 transmit/receive sources.
// - Word5 bits 7..1 gate UART4 error, USB, collisions, UART3; bit 0 unused.
// - Word6 bits 15,14,13,10 used; bits 12..11 and 9..7 are unimplemented.
// - Word6 bits 6..0 gate timers, LCD controller and logic cells 4..1.
// - Word7 bits 5..0 gate JTAG, UART6 and UART5; bits 15..6 unimplemented.
// - A source with a zero three-bit priority is disabled even when enabled.
`ifndef IEBU_CONSTS_SVH
`define IEBU_CONSTS_SVH

// =============================================================================
// Register byte offsets.
`define IEBU_OFF_WORD3  32'h0000_0000
`define IEBU_OFF_WORD4  32'h0000_0004
`define IEBU_OFF_WORD5  32'h0000_0008
`define IEBU_OFF_WORD6  32'h0000_000c
`define IEBU_OFF_WORD7  32'h0000_0010
`define IEBU_OFF_STATUS 32'h0000_0014
`define IEBU_OFF_MASK   32'h0000_0018

// =============================================================================
// Implemented bit masks of the enable words.
`define IEBU_MASK_WORD3 16'h000f
`define IEBU_MASK_WORD4 16'h63cf
`define IEBU_MASK_WORD5 16'hfffe
`define IEBU_MASK_WORD6 16'he47f
`define IEBU_MASK_WORD7 16'h003f

// =============================================================================
// Reset values and field codes.
`define IEBU_EN_RESET   16'h0000
`define IEBU_EVT_RESET  5'h00
`define IEBU_PRIO_OFF   3'h0
`define IEBU_HSIZE_WORD 3'h2

`endif

//--- logic/iebu_pkg.sv
// Types shared by the upper interrupt enable bank.
package iebu_pkg;
  typedef logic [15:0] iebu_word_t;
  typedef logic [47:0] iebu_prio_word_t;
  typedef logic [4:0]  iebu_evt_t;
endpackage : iebu_pkg

//--- logic/iebu_ahb_slave.sv
// AHB-Lite slave front end of the upper interrupt enable bank.
`include "iebu_consts.svh"
module iebu_ahb_slave
  import iebu_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] rdata_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  output logic             wr_o,
  output logic [31:0]      waddr_o,
  output logic             rd_o
);

  logic        take;
  logic        wr_q;
  logic [31:0] waddr_q;
  logic [31:0] hrdata_q;
  logic        ready_q;
  logic        resp_q;

  // A transfer is taken only when selected, valid and a whole word.
  assign take        = hsel_i & hready_i & htrans_i[1] & (hsize_i == `IEBU_HSIZE_WORD);
  assign rd_o        = take & ~hwrite_i;
  assign wr_o        = wr_q;
  assign waddr_o     = waddr_q;
  assign hrdata_o    = hrdata_q;
  assign hreadyout_o = ready_q;
  assign hresp_o     = resp_q;    // Every answer is OKAY.

  // Address phase of a write is held for its data phase.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q    <= 1'b0;
      waddr_q <= 32'h0;
    end else begin
      wr_q <= take & hwrite_i;
      if (take) begin
        waddr_q <= haddr_i;
      end
    end
  end

  // Read data is captured at the address phase so it stands in the data phase.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_q <= 32'h0;
      ready_q  <= 1'b1;
      resp_q   <= 1'b0;
    end else begin
      hrdata_q <= rd_o ? rdata_i : 32'h0;
      ready_q  <= 1'b1;
      resp_q   <= 1'b0;
    end
  end

  // A taken write always produces exactly one write strobe.
  property p_write_strobe;
    @(posedge clk_i) disable iff (rst_i)
      (take && hwrite_i) |=> (wr_o && waddr_o == $past(haddr_i));
  endproperty
  a_write_strobe: assert property (p_write_strobe)
    else $error("Taken write did not raise the write strobe.");

endmodule : iebu_ahb_slave

//--- logic/iebu_top.sv
// Upper interrupt enable bank with request gating and an event interrupt.
//
// Our own choices: register access over AHB-Lite and the register offsets.
`include "iebu_consts.svh"
module iebu_top
  import iebu_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            hsel_i,
  input  wire logic [31:0]     haddr_i,
  input  wire logic [1:0]      htrans_i,
  input  wire logic            hwrite_i,
  input  wire logic [2:0]      hsize_i,
  input  wire logic            hready_i,
  input  wire logic [31:0]     hwdata_i,
  output logic [31:0]          hrdata_o,
  output logic                 hreadyout_o,
  output logic                 hresp_o,
  input  wire iebu_word_t      pend_word3_i,
  input  wire iebu_word_t      pend_word4_i,
  input  wire iebu_word_t      pend_word5_i,
  input  wire iebu_word_t      pend_word6_i,
  input  wire iebu_word_t      pend_word7_i,
  input  wire iebu_prio_word_t prio_word3_i,
  input  wire iebu_prio_word_t prio_word4_i,
  input  wire iebu_prio_word_t prio_word5_i,
  input  wire iebu_prio_word_t prio_word6_i,
  input  wire iebu_prio_word_t prio_word7_i,
  output iebu_word_t           req_word3_o,
  output iebu_word_t           req_word4_o,
  output iebu_word_t           req_word5_o,
  output iebu_word_t           req_word6_o,
  output iebu_word_t           req_word7_o,
  output logic                 irq_o
);

  // ===========================================================================
  // Register map tables.

  localparam int unsigned NUM_WORDS = 5;

  localparam logic [31:0] WORD_OFFS [NUM_WORDS] = '{
    `IEBU_OFF_WORD3,
    `IEBU_OFF_WORD4,
    `IEBU_OFF_WORD5,
    `IEBU_OFF_WORD6,
    `IEBU_OFF_WORD7
  };

  localparam iebu_word_t WORD_MASKS [NUM_WORDS] = '{
    `IEBU_MASK_WORD3,
    `IEBU_MASK_WORD4,
    `IEBU_MASK_WORD5,
    `IEBU_MASK_WORD6,
    `IEBU_MASK_WORD7
  };

  // ===========================================================================
  // Internal signals.

  logic            wr;
  logic [31:0]     waddr;
  logic            rd;
  logic [31:0]     rdata;
  logic            wr_status;
  logic            wr_mask;

  iebu_word_t      pend      [NUM_WORDS];
  iebu_prio_word_t prio      [NUM_WORDS];
  iebu_word_t      prio_ok   [NUM_WORDS];
  iebu_word_t      enable_q  [NUM_WORDS];
  iebu_word_t      enable_d  [NUM_WORDS];
  iebu_word_t      req_q     [NUM_WORDS];
  iebu_word_t      req_d     [NUM_WORDS];
  logic            wr_hit    [NUM_WORDS];

  iebu_evt_t       rise;
  iebu_evt_t       status_q;
  iebu_evt_t       status_d;
  iebu_evt_t       mask_q;
  iebu_evt_t       mask_d;
  logic            irq_q;

  // ===========================================================================
  // Bus front end.

  // The slave takes whole-word transfers with no wait states.
  iebu_ahb_slave u_slave (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hready_i    (hready_i),
    .rdata_i     (rdata),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .hrdata_o    (hrdata_o),
    .wr_o        (wr),
    .waddr_o     (waddr),
    .rd_o        (rd)
  );

  // Source inputs are gathered into arrays indexed by enable word.
  assign pend[0] = pend_word3_i;
  assign pend[1] = pend_word4_i;
  assign pend[2] = pend_word5_i;
  assign pend[3] = pend_word6_i;
  assign pend[4] = pend_word7_i;
  assign prio[0] = prio_word3_i;
  assign prio[1] = prio_word4_i;
  assign prio[2] = prio_word5_i;
  assign prio[3] = prio_word6_i;
  assign prio[4] = prio_word7_i;

  // Gated requests leave straight from their flip-flops.
  assign req_word3_o = req_q[0];
  assign req_word4_o = req_q[1];
  assign req_word5_o = req_q[2];
  assign req_word6_o = req_q[3];
  assign req_word7_o = req_q[4];
  assign irq_o       = irq_q;

  // ===========================================================================
  // Enable words.

  for (genvar w = 0; w < NUM_WORDS; w++) begin : g_word

    // Write decode for this word.
    assign wr_hit[w] = wr && (waddr == WORD_OFFS[w]);

    // Unimplemented positions are masked away so writes there have no effect.
    assign enable_d[w] = wr_hit[w] ? (hwdata_i[15:0] & WORD_MASKS[w])
                                   : enable_q[w];

    // Enable bits clear at reset and otherwise hold the last written value.
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        enable_q[w] <= `IEBU_EN_RESET;
      end else begin
        enable_q[w] <= enable_d[w];
      end
    end

    // A zero priority field marks its source as switched off.
    for (genvar b = 0; b < 16; b++) begin : g_bit
      assign prio_ok[w][b] = (prio[w][3*b +: 3] != `IEBU_PRIO_OFF);
    end

    // The request is the pending flag gated by enable and priority.
    assign req_d[w] = pend[w] & enable_q[w] & prio_ok[w];

    // Requests are registered so each output comes from a flip-flop.
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        req_q[w] <= `IEBU_EN_RESET;
      end else begin
        req_q[w] <= req_d[w];
      end
    end

    // A newly raised request in this word is an event.
    assign rise[w] = |(req_d[w] & ~req_q[w]);

    // Unimplemented bits never hold a one.
    property p_unimpl_zero;
      @(posedge clk_i) disable iff (rst_i)
        (enable_q[w] & ~WORD_MASKS[w]) == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
      else $error("Unimplemented enable bit holds a one.");

    // A write stores exactly the implemented bits of the written data.
    property p_layout;
      @(posedge clk_i) disable iff (rst_i)
        wr_hit[w] |=> (enable_q[w] == ($past(hwdata_i[15:0]) & WORD_MASKS[w]));
    endproperty
    a_layout: assert property (p_layout)
      else $error("Enable word did not store the implemented bits.");

    // A source whose enable is clear is never requested.
    property p_block;
      @(posedge clk_i) disable iff (rst_i)
        ##1 ((req_q[w] & ~$past(enable_q[w])) == 16'h0000);
    endproperty
    a_block: assert property (p_block)
      else $error("Request passed with its enable clear.");

    // A pending, enabled source with nonzero priority is requested next cycle.
    property p_pass;
      @(posedge clk_i) disable iff (rst_i)
        (|(pend[w] & enable_q[w] & prio_ok[w]))
          |=> ((req_q[w] & $past(pend[w] & enable_q[w] & prio_ok[w]))
               == $past(pend[w] & enable_q[w] & prio_ok[w]));
    endproperty
    a_pass: assert property (p_pass)
      else $error("Pending enabled source was not requested.");

    // A source held at priority zero is never requested.
    property p_prio_off;
      @(posedge clk_i) disable iff (rst_i)
        ##1 ((req_q[w] & ~$past(prio_ok[w])) == 16'h0000);
    endproperty
    a_prio_off: assert property (p_prio_off)
      else $error("Request passed with a zero priority.");

  end

  // ===========================================================================
  // Event status and mask.

  assign wr_status = wr && (waddr == `IEBU_OFF_STATUS);
  assign wr_mask   = wr && (waddr == `IEBU_OFF_MASK);

  // Writing one clears a status bit; a new event in the same cycle wins.
  assign status_d = (status_q & ~(wr_status ? hwdata_i[4:0] : `IEBU_EVT_RESET)) | rise;

  // The mask is plain read/write.
  assign mask_d = wr_mask ? hwdata_i[4:0] : mask_q;

  // Status and mask registers.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= `IEBU_EVT_RESET;
      mask_q   <= `IEBU_EVT_RESET;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
    end
  end

  // The interrupt line follows the masked status with no extra lag.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_d);
    end
  end

  // ===========================================================================
  // Read data.

  // Reads see the values after any write in its data phase, so a read
  // right behind a write to the same register returns the new value.
  always_comb begin
    rdata = 32'h0;
    for (int w = 0; w < NUM_WORDS; w++) begin
      if (haddr_i == WORD_OFFS[w]) begin
        rdata = {16'h0000, enable_d[w]};
      end
    end
    if (haddr_i == `IEBU_OFF_STATUS) begin
      rdata = {27'h0, status_d};
    end
    if (haddr_i == `IEBU_OFF_MASK) begin
      rdata = {27'h0, mask_d};
    end
  end

  // ===========================================================================
  // Checks.

  // All enable words read zero at the first edge after reset.
  property p_reset_clear;
    @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> (enable_q[0] == 16'h0000 && enable_q[1] == 16'h0000
                        && enable_q[2] == 16'h0000 && enable_q[3] == 16'h0000
                        && enable_q[4] == 16'h0000);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("Enable bits not clear after reset.");

  // A read of enable word4 never shows upper or unimplemented bits.
  property p_read_unimpl;
    @(posedge clk_i) disable iff (rst_i)
      (rd && haddr_i == `IEBU_OFF_WORD4)
        |=> (hrdata_o[31:16] == 16'h0000 && (hrdata_o[15:0] & ~`IEBU_MASK_WORD4) == 16'h0000);
  endproperty
  a_read_unimpl: assert property (p_read_unimpl)
    else $error("Read returned a one in an unimplemented bit.");

  // An event that meets a clear of its bit still leaves the bit set.
  property p_set_wins;
    @(posedge clk_i) disable iff (rst_i)
      (|rise) |=> ((status_q & $past(rise)) == $past(rise));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Status event was lost.");

  // The interrupt line tracks the masked status.
  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
      irq_o == (|(status_q & mask_q));
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt line disagrees with masked status.");

  // Writing ones to the status register clears those bits unless a new event lands.
  property p_status_clear;
    @(posedge clk_i) disable iff (rst_i)
      wr_status |=> ((status_q & $past(hwdata_i[4:0]) & ~$past(rise)) == 5'h00);
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("Status bit survived its clear.");

  // The mask register stores the written low bits.
  property p_mask_rw;
    @(posedge clk_i) disable iff (rst_i)
      wr_mask |=> (mask_q == $past(hwdata_i[4:0]));
  endproperty
  a_mask_rw: assert property (p_mask_rw)
    else $error("Mask register did not store the written bits.");

  // A read of the lowest enable word returns that word in its data phase.
  property p_read_word;
    @(posedge clk_i) disable iff (rst_i)
      (rd && haddr_i == `IEBU_OFF_WORD3) |=> (hrdata_o == {16'h0000, enable_q[0]});
  endproperty
  a_read_word: assert property (p_read_word)
    else $error("Read data differs from the enable word.");

  // Read data is zero in any cycle that does not follow a taken read.
  property p_idle_data;
    @(posedge clk_i) disable iff (rst_i)
      !rd |=> (hrdata_o == 32'h0000_0000);
  endproperty
  a_idle_data: assert property (p_idle_data)
    else $error("Read data stood without a read.");

  // The bus never waits and never reports an error.
  property p_bus_okay;
    @(posedge clk_i) disable iff (rst_i)
      hreadyout_o && !hresp_o;
  endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("Bus answer was not a ready OKAY.");

  // Requests, status, mask and the interrupt line are clear at the first edge after reset.
  property p_out_reset;
    @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> (status_q == 5'h00 && mask_q == 5'h00 && !irq_o
                        && (req_q[0] | req_q[1] | req_q[2] | req_q[3] | req_q[4]) == 16'h0000);
  endproperty
  a_out_reset: assert property (p_out_reset)
    else $error("Outputs not clear after reset.");

endmodule : iebu_top

//--- tb/iebu_src_model.sv
// Behavioural model of the peripheral sources that feed the enable bank.
module iebu_src_model
  import iebu_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire logic [4:0] fire_i,
  input  wire logic [4:0] prio_on_i,
  output iebu_word_t      pend_o [5],
  output iebu_prio_word_t prio_o [5]
);
  timeunit 1ns;
  timeprecision 1ps;

  // =============================================================================
  // Pending flags and priorities.
  // Each word raises all sixteen flags when fired, as real sources are already routed.
  always_ff @(posedge clk_i or posedge rst_i) begin
    for (int w = 0; w < 5; w++) begin
      if (rst_i) begin
        pend_o[w] <= 16'h0000;
        prio_o[w] <= 48'h0000_0000_0000;
      end else begin
        pend_o[w] <= fire_i[w] ? 16'hffff : 16'h0000;
        prio_o[w] <= prio_on_i[w] ? {16{3'(w + 1)}} : 48'h0000_0000_0000;
      end
    end
  end
endmodule : iebu_src_model

//--- tb/iebu_top_tb_top.sv
// Self-checking testbench of the upper interrupt enable bank.
`include "iebu_consts.svh"
module iebu_top_tb_top
  import iebu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // =============================================================================
  // Signals.
  logic            clk_i, rst_i, hsel, hwrite, hready, hresp, irq, irq_s, rdy_s;
  logic [31:0]     haddr, hwdata, hrdata, rd_s, rdv;
  logic [1:0]      htrans;
  logic [2:0]      hsize;
  logic [4:0]      fire, prio_on;
  iebu_word_t      pend [5];
  iebu_prio_word_t prio [5];
  iebu_word_t      req [5];
  iebu_word_t      req_s [5];
  int              fails = 0;
  int              n_checks = 0;
  logic [31:0]     offs [5] = '{`IEBU_OFF_WORD3, `IEBU_OFF_WORD4, `IEBU_OFF_WORD5,
                                `IEBU_OFF_WORD6, `IEBU_OFF_WORD7};
  iebu_word_t      masks [5] = '{`IEBU_MASK_WORD3, `IEBU_MASK_WORD4, `IEBU_MASK_WORD5,
                                 `IEBU_MASK_WORD6, `IEBU_MASK_WORD7};

  // =============================================================================
  // Design, source model and clock.
  iebu_top uut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hready),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .pend_word3_i(pend[0]), .pend_word4_i(pend[1]), .pend_word5_i(pend[2]),
    .pend_word6_i(pend[3]), .pend_word7_i(pend[4]), .prio_word3_i(prio[0]),
    .prio_word4_i(prio[1]), .prio_word5_i(prio[2]), .prio_word6_i(prio[3]),
    .prio_word7_i(prio[4]), .req_word3_o(req[0]), .req_word4_o(req[1]),
    .req_word5_o(req[2]), .req_word6_o(req[3]), .req_word7_o(req[4]), .irq_o(irq));

  iebu_src_model model (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .prio_on_i(prio_on),
    .pend_o(pend), .prio_o(prio));

  // The clock toggles every half period of 10 ns.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Outputs change only at rising edges, so the falling edge gives a race-free snapshot.
  always @(negedge clk_i) begin
    rd_s  <= hrdata;
    rdy_s <= hready;
    irq_s <= irq;
    req_s <= req;
  end

  // =============================================================================
  // Shared tasks.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Waits until the falling-edge snapshot of hready reads high at a rising edge, with a bounded count.
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk_i);
    while (rdy_s !== 1'b1) begin
      n++;
      if (n > 20) begin
        check("hready", {31'h0, rdy_s}, 32'h1);
        end_of_test();
      end
      @(posedge clk_i);
    end
  endtask : wait_ready

  // One single word transfer; read data lands in rdv.
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rdv = rd_s;
  endtask : ahb

  // Lets source model and request registers settle.
  task automatic settle();
    repeat (4) @(posedge clk_i);
  endtask : settle

  // =============================================================================
  // Scenarios.
  task automatic sc_reset();
    for (int w = 0; w < 5; w++) begin
      ahb(1'b0, offs[w], 32'h0);
      check("enable reset", rdv, 32'h0);
    end
    check("okay response", {31'h0, hresp}, 32'h0);
  endtask : sc_reset

  // All ones and all zeros per word; unused bits and unmapped places stay zero.
  task automatic sc_rw();
    for (int w = 0; w < 5; w++) begin
      ahb(1'b1, offs[w], 32'hffff_ffff);
      ahb(1'b0, offs[w], 32'h0);
      check("enable ones", rdv, {16'h0, masks[w]});
      ahb(1'b1, offs[w], 32'h0);
      ahb(1'b0, offs[w], 32'h0);
      check("enable zeros", rdv, 32'h0);
    end
    ahb(1'b1, 32'h0000_001c, 32'hffff_ffff);
    ahb(1'b0, 32'h0000_001c, 32'h0);
    check("unmapped", rdv, 32'h0);
    hsize <= 3'h0;
    ahb(1'b1, offs[1], 32'hffff_ffff);
    hsize <= `IEBU_HSIZE_WORD;
    ahb(1'b0, offs[1], 32'h0);
    check("byte write", rdv, 32'h0);
  endtask : sc_rw

  // Requests follow pending, enable and nonzero priority together.
  task automatic sc_gate();
    fire    <= 5'h1f;
    prio_on <= 5'h1f;
    settle();
    for (int w = 0; w < 5; w++) check("req blocked", 32'(req_s[w]), 32'h0);
    for (int w = 0; w < 5; w++) ahb(1'b1, offs[w], 32'hffff_ffff);
    settle();
    for (int w = 0; w < 5; w++) check("req passed", 32'(req_s[w]), 32'(masks[w]));
    prio_on <= 5'h15;
    settle();
    for (int w = 0; w < 5; w++) begin
      check("req prio", 32'(req_s[w]), w % 2 ? 32'h0 : 32'(masks[w]));
    end
    fire <= 5'h00;
    settle();
    for (int w = 0; w < 5; w++) check("req idle", 32'(req_s[w]), 32'h0);
  endtask : sc_gate

  // Event on the lowest word sets its status bit and the masked interrupt.
  task automatic sc_irq();
    prio_on <= 5'h1f;
    ahb(1'b1, `IEBU_OFF_STATUS, 32'h0000_001f);
    ahb(1'b1, `IEBU_OFF_MASK, 32'h0000_0001);
    settle();
    check("irq idle", {31'h0, irq_s}, 32'h0);
    fire <= 5'h01;
    settle();
    check("irq raised", {31'h0, irq_s}, 32'h1);
    ahb(1'b0, `IEBU_OFF_STATUS, 32'h0);
    check("status set", rdv, 32'h1);
    ahb(1'b1, `IEBU_OFF_MASK, 32'h0);
    settle();
    check("irq masked", {31'h0, irq_s}, 32'h0);
    ahb(1'b1, `IEBU_OFF_MASK, 32'h0000_0001);
    fire <= 5'h00;
    settle();
    check("irq unmasked", {31'h0, irq_s}, 32'h1);
    ahb(1'b1, `IEBU_OFF_STATUS, 32'h0000_0001);
    settle();
    check("irq cleared", {31'h0, irq_s}, 32'h0);
    ahb(1'b0, `IEBU_OFF_STATUS, 32'h0);
    check("status clear", rdv, 32'h0);
  endtask : sc_irq

  // A reset in mid-run clears enables, requests, status, mask and the interrupt.
  task automatic sc_rst_mid();
    fire <= 5'h1f;
    ahb(1'b1, `IEBU_OFF_MASK, 32'h0000_001f);
    settle();
    check("irq before reset", {31'h0, irq_s}, 32'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    check("irq after reset", {31'h0, irq_s}, 32'h0);
    for (int w = 0; w < 5; w++) begin
      check("req after reset", 32'(req_s[w]), 32'h0);
      ahb(1'b0, offs[w], 32'h0);
      check("enable after reset", rdv, 32'h0);
    end
    ahb(1'b0, `IEBU_OFF_MASK, 32'h0);
    check("mask after reset", rdv, 32'h0);
    ahb(1'b0, `IEBU_OFF_STATUS, 32'h0);
    check("status after reset", rdv, 32'h0);
  endtask : sc_rst_mid

  // =============================================================================
  // Verdict and main sequence.
  task automatic end_of_test();
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    rst_i   <= 1'b1;
    hsel    <= 1'b0;
    haddr   <= 32'h0;
    htrans  <= 2'h0;
    hwrite  <= 1'b0;
    hsize   <= `IEBU_HSIZE_WORD;
    hwdata  <= 32'h0;
    fire    <= 5'h00;
    prio_on <= 5'h00;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    sc_reset();
    sc_rw();
    sc_gate();
    sc_irq();
    sc_rst_mid();
    end_of_test();
  end
endmodule : iebu_top_tb_top
